// [hdl/indication_hold.v]
`include "reclose_cfg_defines.vh"
`default_nettype none

// ----------------------------------------------------------------------
// Trip indication latch with a minute-based hold timer
// ----------------------------------------------------------------------
module indication_hold #(
   parameter NSTAGE        = 8,
   parameter MINUTE_CYCLES = `MINUTE_CYCLES
) (
   input  wire                    mclk,
   input  wire                    rst,
   input  wire [NSTAGE-1:0]       trip_in,
   input  wire [`HOLD_TIME_W-1:0] hold_minutes,
   input  wire                    clear_req,
   output reg  [NSTAGE-1:0]       shown_reg,
   output reg                     valid_reg
);

   // Cycle counter for one minute and minute counter.
   reg [31:0]              tick_reg;
   reg [`HOLD_TIME_W-1:0]  min_reg;
   // Set once the hold time has run out.
   reg                     expired_reg;
   // Trips that are new this cycle.
   reg [NSTAGE-1:0]        trip_prev_reg;
   wire [NSTAGE-1:0]       trip_rise;
   wire                    replace_ok;

   assign trip_rise  = trip_in & ~trip_prev_reg;
   assign replace_ok = expired_reg && (hold_minutes != `HOLD_TIME_MANUAL);

   // ------------------------------------------------------------------
   // Latch and timer process
   // ------------------------------------------------------------------
   always @(posedge mclk) begin
      trip_prev_reg <= trip_in;
      if (rst) begin
         shown_reg     <= {NSTAGE{1'b0}};
         valid_reg     <= 1'b0;
         tick_reg      <= 32'h0000_0000;
         min_reg       <= {`HOLD_TIME_W{1'b0}};
         expired_reg   <= 1'b0;
         trip_prev_reg <= {NSTAGE{1'b0}};
      end else if (clear_req) begin
         // Clearing empties the display and reloads the timer.
         shown_reg   <= {NSTAGE{1'b0}};
         valid_reg   <= 1'b0;
         tick_reg    <= 32'h0000_0000;
         min_reg     <= {`HOLD_TIME_W{1'b0}};
         expired_reg <= 1'b0;
      end else if ((!valid_reg || replace_ok) && (trip_rise != {NSTAGE{1'b0}})) begin
         // First trip, or a later one after expiry when the hold is not manual, is latched.
         shown_reg   <= trip_rise;
         valid_reg   <= 1'b1;
         tick_reg    <= 32'h0000_0000;
         min_reg     <= {`HOLD_TIME_W{1'b0}};
         expired_reg <= (hold_minutes == {`HOLD_TIME_W{1'b0}});
      end else if (valid_reg && !expired_reg) begin
         // Count whole minutes against the setting.
         if (min_reg >= hold_minutes) begin
            expired_reg <= 1'b1;
         end else if (tick_reg == MINUTE_CYCLES - 1) begin
            tick_reg <= 32'h0000_0000;
            min_reg  <= min_reg + 1'b1;
         end else begin
            tick_reg <= tick_reg + 32'h0000_0001;
         end
      end
   end

endmodule
`default_nettype wire

// [hdl/reclose_block_ctrl.v]
`include "reclose_cfg_defines.vh"
`default_nettype none

// ----------------------------------------------------------------------
// Reclose blocking, inhibit and retention configuration logic
// ----------------------------------------------------------------------
// Stage order on the five trip vectors: low-set overcurrent, high-set
// overcurrent, instantaneous overcurrent, low-set earth fault, high-set
// earth fault. Settings are written through a strobed settings port.
module reclose_block_ctrl #(
   parameter MINUTE_CYCLES = `MINUTE_CYCLES
) (
   input  wire                         mclk,
   input  wire                         rst,
   // Settings port.
   input  wire                         set_wr,
   input  wire [2:0]                   set_sel,
   input  wire [15:0]                  set_data,
   // Asynchronous protection inputs (stage trips, starts, alarms).
   input  wire [4:0]                   stage_trip,
   input  wire                         lowset_delayed_start,
   input  wire                         ef_lowset_delayed_start,
   input  wire                         ext_reclose_req,
   input  wire                         thermal_alarm,
   input  wire                         phase_discont_trip,
   input  wire                         thermal_trip,
   // Auto-reclose sequencer state, same clock domain.
   input  wire [1:0]                   shot_number,
   input  wire                         cutout_expired,
   input  wire                         reclaim_expired,
   input  wire                         auto_reclose_lockout,
   input  wire                         close_command,
   input  wire                         manual_clear,
   // Outputs.
   output reg  [4:0]                   trip_out,
   output reg  [3:0]                   shot_start_ok,
   output reg                          auto_reclose_inhibit,
   output reg  [7:0]                   indication_shown,
   output reg                          indication_valid,
   output reg  [`RETENTION_W-1:0]      retain_flags,
   output reg                          battery_supervision_en,
   output reg  [`SHOT_INIT_BLOCK_W-1:0] rd_shot_init,
   output reg  [`STAGE_TRIP_BLOCK_W-1:0] rd_stage_trip,
   output reg  [`INHIBIT_SELECT_W-1:0] rd_inhibit,
   output reg  [`HOLD_TIME_W-1:0]      rd_hold_time
);

   // ------------------------------------------------------------------
   // Settings selectors
   // ------------------------------------------------------------------
   localparam [2:0] SEL_SHOT_INIT = 3'h0;
   localparam [2:0] SEL_STAGE     = 3'h1;
   localparam [2:0] SEL_INHIBIT   = 3'h2;
   localparam [2:0] SEL_RETAIN    = 3'h3;
   localparam [2:0] SEL_HOLD      = 3'h4;

   // Shot block states.
   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_SHOT1  = 2'h1;
   localparam [1:0] ST_SHOT23 = 2'h2;

   // Setting registers.
   reg [`SHOT_INIT_BLOCK_W-1:0]  shot_initiation_block_reg;
   reg [`STAGE_TRIP_BLOCK_W-1:0] stage_trip_block_reg;
   reg [`INHIBIT_SELECT_W-1:0]   reclose_inhibit_select_reg;
   reg [`RETENTION_W-1:0]        power_loss_retention_reg;
   reg [`HOLD_TIME_W-1:0]        indication_hold_time_reg;

   // Two-stage synchronisers for pin inputs.
   reg [10:0] sync1_reg;
   reg [10:0] sync2_reg;
   wire [10:0] pin_raw;

   // Block state machine.
   reg [1:0] blk_state_reg;
   reg [1:0] blk_state_next;

   // Synchronised signal views.
   wire [4:0] trip_s;
   wire       lsd_s;
   wire       efd_s;
   wire       ext_s;
   wire       th_alarm_s;
   wire       pd_trip_s;
   wire       th_trip_s;

   // Selected field per shot.
   reg [3:0] init_field;
   reg [4:0] stage_field;
   reg [4:0] trip_next;
   reg [3:0] start_next;
   reg       inhibit_next;
   wire      ind_clear;
   wire [7:0] shown_w;
   wire       valid_w;

   assign pin_raw = {thermal_trip, phase_discont_trip, thermal_alarm, ext_reclose_req,
                     ef_lowset_delayed_start, lowset_delayed_start, stage_trip};
   assign trip_s     = sync2_reg[4:0];
   assign lsd_s      = sync2_reg[5];
   assign efd_s      = sync2_reg[6];
   assign ext_s      = sync2_reg[7];
   assign th_alarm_s = sync2_reg[8];
   assign pd_trip_s  = sync2_reg[9];
   assign th_trip_s  = sync2_reg[10];

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   // Every pin input passes two flip-flops before any logic reads it.
   always @(posedge mclk) begin
      if (rst) begin
         sync1_reg <= 11'h000;
         sync2_reg <= 11'h000;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   // ------------------------------------------------------------------
   // Settings registers
   // ------------------------------------------------------------------
   // Each switch group is written whole; the retention switches too are
   // written as one group, although each bit stands alone.
   always @(posedge mclk) begin
      if (rst) begin
         shot_initiation_block_reg  <= `SHOT_INIT_BLOCK_RST;
         stage_trip_block_reg       <= `STAGE_TRIP_BLOCK_RST;
         reclose_inhibit_select_reg <= `INHIBIT_SELECT_RST;
         power_loss_retention_reg   <= `RETENTION_RST;
         indication_hold_time_reg   <= `HOLD_TIME_RST;
      end else if (set_wr) begin
         case (set_sel)
            SEL_SHOT_INIT: begin
               shot_initiation_block_reg <= set_data[`SHOT_INIT_BLOCK_W-1:0];
            end
            SEL_STAGE: begin
               stage_trip_block_reg <= set_data[`STAGE_TRIP_BLOCK_W-1:0];
            end
            SEL_INHIBIT: begin
               reclose_inhibit_select_reg <= set_data[`INHIBIT_SELECT_W-1:0];
            end
            SEL_RETAIN: begin
               power_loss_retention_reg <= set_data[`RETENTION_W-1:0];
            end
            SEL_HOLD: begin
               indication_hold_time_reg <= set_data[`HOLD_TIME_W-1:0];
            end
            default: begin
               // Unknown selectors are ignored.
               shot_initiation_block_reg <= shot_initiation_block_reg;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Stage-trip block state machine
   // ------------------------------------------------------------------
   // The block enters with the shot and stays until cutout, reclaim
   // or lockout ends it, whichever comes first.
   always @* begin
      blk_state_next = blk_state_reg;
      case (blk_state_reg)
         ST_IDLE: begin
            if (!auto_reclose_lockout && shot_number == 2'd1) begin
               blk_state_next = ST_SHOT1;
            end else if (!auto_reclose_lockout && shot_number >= 2'd2) begin
               blk_state_next = ST_SHOT23;
            end
         end
         ST_SHOT1, ST_SHOT23: begin
            if (cutout_expired || reclaim_expired || auto_reclose_lockout) begin
               blk_state_next = ST_IDLE;
            end else if (shot_number >= 2'd2) begin
               blk_state_next = ST_SHOT23;
            end
         end
         default: begin
            blk_state_next = ST_IDLE;
         end
      endcase
   end

   // State register.
   always @(posedge mclk) begin
      if (rst) begin
         blk_state_reg <= ST_IDLE;
      end else begin
         blk_state_reg <= blk_state_next;
      end
   end

   // ------------------------------------------------------------------
   // Field selection and gating
   // ------------------------------------------------------------------
   always @* begin
      // Pick the first-shot or later-shot initiation field from the shot number, the stage field from the block state.
      if (shot_number >= 2'd2) begin
         init_field = shot_initiation_block_reg[`SHOT23_FIELD_LSB +: 4];
      end else begin
         init_field = shot_initiation_block_reg[`SHOT1_FIELD_LSB +: 4];
      end
      case (blk_state_reg)
         ST_SHOT1:  stage_field = stage_trip_block_reg[`STAGE_SHOT1_LSB +: 5];
         ST_SHOT23: stage_field = stage_trip_block_reg[`STAGE_SHOT23_LSB +: 5];
         default:   stage_field = 5'h00;
      endcase
      // Blocked stages have their trip suppressed; hold timer not involved.
      trip_next = trip_s & ~stage_field;
      // Initiation sources: high-set, external, low-set, earth fault.
      start_next[0] = trip_s[1] & ~init_field[0];
      start_next[1] = ext_s & ~init_field[1];
      start_next[2] = (trip_s[0] | lsd_s) & ~init_field[2];
      start_next[3] = (trip_s[3] | efd_s | trip_s[4]) & ~init_field[3];
      // Inhibit sources: instantaneous, high-set earth fault, thermal, phase.
      inhibit_next = (reclose_inhibit_select_reg[0] & trip_s[2])
                   | (reclose_inhibit_select_reg[1] & trip_s[4])
                   | (reclose_inhibit_select_reg[2] & th_alarm_s)
                   | (reclose_inhibit_select_reg[3] & pd_trip_s);
   end

   // Indications clear on manual request or, if enabled, on reclosing.
   assign ind_clear = manual_clear |
                      (close_command & reclose_inhibit_select_reg[`INDICATION_RESET_BIT]);

   // ------------------------------------------------------------------
   // Indication hold
   // ------------------------------------------------------------------
   indication_hold #(
      .NSTAGE        (8),
      .MINUTE_CYCLES (MINUTE_CYCLES)
   ) i_indication_hold (
      .mclk         (mclk),
      .rst          (rst),
      .trip_in      ({th_trip_s, pd_trip_s, th_alarm_s, trip_s}),
      .hold_minutes (indication_hold_time_reg),
      .clear_req    (ind_clear),
      .shown_reg    (shown_w),
      .valid_reg    (valid_w)
   );

   // ------------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         trip_out               <= 5'h00;
         shot_start_ok          <= 4'h0;
         auto_reclose_inhibit   <= 1'b0;
         indication_shown       <= 8'h00;
         indication_valid       <= 1'b0;
         retain_flags           <= `RETENTION_RST;
         battery_supervision_en <= 1'b1;
         rd_shot_init           <= `SHOT_INIT_BLOCK_RST;
         rd_stage_trip          <= `STAGE_TRIP_BLOCK_RST;
         rd_inhibit             <= `INHIBIT_SELECT_RST;
         rd_hold_time           <= `HOLD_TIME_RST;
      end else begin
         trip_out             <= trip_next;
         shot_start_ok        <= start_next;
         auto_reclose_inhibit <= inhibit_next;
         indication_shown     <= shown_w;
         indication_valid     <= valid_w;
         // Bit 0 indications, 1 recorder, 2 events, 3 counters, 4 clock.
         retain_flags <= power_loss_retention_reg;
         battery_supervision_en <= (power_loss_retention_reg != 5'h00);
         rd_shot_init  <= shot_initiation_block_reg;
         rd_stage_trip <= stage_trip_block_reg;
         rd_inhibit    <= reclose_inhibit_select_reg;
         rd_hold_time  <= indication_hold_time_reg;
      end
   end

endmodule
`default_nettype wire

// [pkg/reclose_cfg_defines.vh]
`ifndef RECLOSE_CFG_DEFINES_VH
`define RECLOSE_CFG_DEFINES_VH

// ----------------------------------------------------------------------
// Register widths and reset values
// ----------------------------------------------------------------------
`define SHOT_INIT_BLOCK_W     8
`define SHOT_INIT_BLOCK_RST   8'h00
`define STAGE_TRIP_BLOCK_W    10
`define STAGE_TRIP_BLOCK_RST  10'h000
`define INHIBIT_SELECT_W      5
`define INHIBIT_SELECT_RST    5'h0F
`define RETENTION_W           5
`define RETENTION_RST         5'h1F
`define HOLD_TIME_W           10
`define HOLD_TIME_RST         10'h03C
`define HOLD_TIME_MANUAL      10'h3E7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SHOT1_FIELD_LSB       0
`define SHOT23_FIELD_LSB      4
`define STAGE_SHOT1_LSB       0
`define STAGE_SHOT23_LSB      5
`define INDICATION_RESET_BIT  4
`define RET_INDICATION_BIT    0
`define RET_RECORDER_BIT      1
`define RET_EVENTS_BIT        2
`define RET_COUNTERS_BIT      3
`define RET_CLOCK_BIT         4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ           10000000
`define SECONDS_PER_MINUTE    60
`define MINUTE_CYCLES         (`CLK_FREQ_HZ * `SECONDS_PER_MINUTE)

`endif

// [verification/reclose_block_ctrl_checker.sv]
`default_nettype none
// ------------------------------------------------------------------
// Port-level checks on the reclose blocking control
// ------------------------------------------------------------------
module reclose_block_ctrl_checker (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        set_wr,
   input wire logic [2:0]  set_sel,
   input wire logic [15:0] set_data,
   input wire logic [4:0]  stage_trip,
   input wire logic        ext_reclose_req,
   input wire logic [1:0]  shot_number,
   input wire logic        manual_clear,
   input wire logic [4:0]  trip_out,
   input wire logic [3:0]  shot_start_ok,
   input wire logic        auto_reclose_inhibit,
   input wire logic [7:0]  indication_shown,
   input wire logic        indication_valid,
   input wire logic [4:0]  retain_flags,
   input wire logic        battery_supervision_en,
   input wire logic [7:0]  rd_shot_init,
   input wire logic [9:0]  rd_stage_trip,
   input wire logic [4:0]  rd_inhibit,
   input wire logic [9:0]  rd_hold_time
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking chk_clk @(posedge mclk); endclocking
   default disable iff (rst);

   // A settings write shows on its readback two edges later.
   property rd_follow(logic [2:0] s, logic [15:0] rv, logic [15:0] m);
      logic [15:0] d;
      (set_wr && set_sel == s, d = set_data) |-> ##2 rv == (d & m);
   endproperty
   // Pin and setting histories long enough to cross the synchronisers.
   sequence inh_cause;
      (stage_trip[2] && rd_inhibit[0])[*5];
   endsequence
   sequence inh_none;
      (rd_inhibit[3:0] == 4'h0)[*5];
   endsequence
   sequence ext_free;
      (ext_reclose_req && shot_number < 2'h2 && !rd_shot_init[1])[*5];
   endsequence
   sequence ext_blocked;
      (shot_number >= 2'h2 && rd_shot_init[5])[*5];
   endsequence
   sequence held_manual;
      (indication_valid && rd_hold_time == 10'h3E7)[*4];
   endsequence

   rd_shot_a: assert property (rd_follow(3'h0, rd_shot_init, 16'h00FF))
      else $error("shot block readback wrong");
   rd_stage_a: assert property (rd_follow(3'h1, rd_stage_trip, 16'h03FF))
      else $error("stage block readback wrong");
   rd_inhibit_a: assert property (rd_follow(3'h2, rd_inhibit, 16'h001F))
      else $error("inhibit select readback wrong");
   retain_copy_a: assert property (rd_follow(3'h3, retain_flags, 16'h001F))
      else $error("retention flags wrong");
   rd_hold_a: assert property (rd_follow(3'h4, rd_hold_time, 16'h03FF))
      else $error("hold time readback wrong");
   trip_gate_a: assert property ((trip_out & ~$past(stage_trip, 3)) == 5'h00)
      else $error("trip output without stage trip");
   inhibit_on_a: assert property (inh_cause |-> auto_reclose_inhibit)
      else $error("enabled inhibit source ignored");
   inhibit_off_a: assert property (inh_none |-> !auto_reclose_inhibit)
      else $error("inhibit with all sources disabled");
   start_free_a: assert property (ext_free |-> shot_start_ok[1])
      else $error("unblocked external start refused");
   start_block_a: assert property (ext_blocked |-> !shot_start_ok[1])
      else $error("blocked external start allowed");
   hold_manual_a: assert property (held_manual |-> $stable(indication_shown))
      else $error("indication replaced under manual hold");
   clear_ind_a: assert property (manual_clear |-> ##[1:3] !indication_valid)
      else $error("manual clear ignored");
   battery_off_a: assert property ((retain_flags == 5'h00)[*2] |-> !battery_supervision_en)
      else $error("battery supervision left on");
endmodule
`default_nettype wire

// [verification/reclose_block_ctrl_tb.sv]
`include "reclose_cfg_defines.vh"
`default_nettype none
module reclose_block_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, rst, set_wr, lowset_delayed_start, ef_lowset_delayed_start;
   logic        ext_reclose_req, thermal_alarm, phase_discont_trip, thermal_trip, manual_clear;
   logic        cutout_expired, reclaim_expired, auto_reclose_lockout, close_command;
   logic        auto_reclose_inhibit, indication_valid, battery_supervision_en;
   logic [1:0]  shot_number;
   logic [2:0]  set_sel;
   logic [3:0]  shot_start_ok;
   logic [4:0]  stage_trip, trip_out, retain_flags, rd_inhibit;
   logic [7:0]  indication_shown, rd_shot_init;
   logic [9:0]  rd_stage_trip, rd_hold_time;
   logic [15:0] set_data;
   int          error_cnt = 0;
   int          cmp_count = 0;

   reclose_block_ctrl #(.MINUTE_CYCLES(10)) i_reclose_block_ctrl (.mclk, .rst, .set_wr,
      .set_sel, .set_data, .stage_trip, .lowset_delayed_start, .ef_lowset_delayed_start,
      .ext_reclose_req, .thermal_alarm, .phase_discont_trip, .thermal_trip, .shot_number,
      .cutout_expired, .reclaim_expired, .auto_reclose_lockout, .close_command, .manual_clear,
      .trip_out, .shot_start_ok, .auto_reclose_inhibit, .indication_shown,
      .indication_valid, .retain_flags, .battery_supervision_en, .rd_shot_init,
      .rd_stage_trip, .rd_inhibit, .rd_hold_time);
   reclose_seq_model i_reclose_seq_model (.mclk, .shot_number, .cutout_expired,
      .reclaim_expired, .auto_reclose_lockout, .close_command);

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Waits n edges, then steps just past the edge where the bench drives.
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #10;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      set_wr = 1'b1;
      set_sel = s;
      set_data = d;
      tick(1);
      set_wr = 1'b0;
      tick(2);
   endtask
   function automatic logic [15:0] rdv(input int s);
      case (s)
         0: rdv = {8'h00, rd_shot_init};
         1: rdv = {6'h00, rd_stage_trip};
         2: rdv = {11'h000, rd_inhibit};
         3: rdv = {11'h000, retain_flags};
         default: rdv = {6'h00, rd_hold_time};
      endcase
   endfunction
   task automatic src(input int i, input logic v);
      case (i)
         0: stage_trip[2] = v;
         1: stage_trip[4] = v;
         2: thermal_alarm = v;
         default: phase_discont_trip = v;
      endcase
   endtask
   task automatic t_regs();
      logic [15:0] rv [5] = '{16'h0000, 16'h0000, 16'h000F, 16'h001F, 16'h003C};
      logic [15:0] wv [5] = '{16'h00A5, 16'h02C3, 16'h0010, 16'h0000, 16'h03E7};
      for (int s = 0; s < 5; s++) chk("reset value", rdv(s), rv[s]);
      chk("battery", battery_supervision_en, 16'h0001);
      for (int s = 0; s < 5; s++) begin
         wr(3'(s), wv[s]);
         chk("readback", rdv(s), wv[s]);
      end
      tick(2);
      chk("battery off", battery_supervision_en, 16'h0000);
      wr(3'h5, 16'hFFFF);
      for (int s = 0; s < 5; s++) chk("unused select", rdv(s), wv[s]);
      for (int b = 0; b < 5; b++) begin
         wr(3'h3, 16'h0001 << b);
         chk("retain", retain_flags, 16'h0001 << b);
      end
      for (int s = 0; s < 5; s++) wr(3'(s), rv[s]);
      $display("register test done");
   endtask
   task automatic t_inhibit();
      for (int i = 0; i < 4; i++) begin
         src(i, 1'b1);
         tick(5);
         chk("inhibit on", auto_reclose_inhibit, 16'h0001);
         wr(3'h2, 16'h000F ^ (16'h0001 << i));
         tick(4);
         chk("inhibit masked", auto_reclose_inhibit, 16'h0000);
         wr(3'h2, 16'h000F);
         src(i, 1'b0);
      end
      $display("inhibit test done");
   endtask
   task automatic t_trip_block();
      logic [1:0] shot [3] = '{2'h1, 2'h2, 2'h3};
      logic [1:0] endk [3] = '{2'h2, 2'h3, 2'h1};
      wr(3'h1, 16'h0041);
      stage_trip = 5'h1F;
      tick(5);
      chk("trip idle", trip_out, 16'h001F);
      for (int k = 0; k < 3; k++) begin
         i_reclose_seq_model.start_shot(shot[k]);
         tick(5);
         chk("trip in shot", trip_out, (shot[k] == 2'h1) ? 16'h001E : 16'h001D);
         i_reclose_seq_model.end_shot(endk[k]);
         tick(5);
         chk("trip after shot", trip_out, 16'h001F);
      end
      stage_trip = 5'h00;
      wr(3'h1, 16'h0000);
      $display("trip block test done");
   endtask
   task automatic t_init_block();
      wr(3'h0, 16'h0021);
      {ext_reclose_req, lowset_delayed_start, ef_lowset_delayed_start} = 3'h7;
      stage_trip = 5'h02;
      tick(5);
      chk("start shot one", shot_start_ok, 16'h000E);
      i_reclose_seq_model.start_shot(2'h2);
      tick(5);
      chk("start later shot", shot_start_ok, 16'h000D);
      i_reclose_seq_model.end_shot(2'h2);
      wr(3'h0, 16'h0000);
      tick(4);
      chk("start unblocked", shot_start_ok, 16'h000F);
      {ext_reclose_req, lowset_delayed_start, ef_lowset_delayed_start} = 3'h0;
      stage_trip = 5'h00;
      $display("initiation test done");
   endtask
   task automatic t_indication();
      manual_clear = 1'b1;
      tick(1);
      manual_clear = 1'b0;
      wr(3'h4, 16'h0002);
      chk("cleared", indication_valid, 16'h0000);
      stage_trip = 5'h01;
      tick(6);
      chk("first shown", indication_shown, 16'h0001);
      stage_trip = 5'h03;
      tick(6);
      chk("first held", indication_shown, 16'h0001);
      tick(20);
      stage_trip = 5'h0B;
      tick(6);
      chk("replaced", indication_shown, 16'h0008);
      wr(3'h4, 16'h03E7);
      tick(30);
      stage_trip = 5'h1B;
      tick(6);
      chk("manual hold", indication_shown, 16'h0008);
      chk("trip unaffected", trip_out, 16'h001B);
      manual_clear = 1'b1;
      tick(1);
      manual_clear = 1'b0;
      stage_trip = 5'h00;
      wr(3'h2, 16'h001F);
      stage_trip = 5'h01;
      tick(6);
      chk("relatched", indication_valid, 16'h0001);
      i_reclose_seq_model.close_pulse();
      tick(4);
      chk("close clears", indication_valid, 16'h0000);
      stage_trip = 5'h00;
      $display("indication test done");
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge mclk);
      error_cnt++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      {rst, set_wr, set_sel, set_data, stage_trip} = {1'b1, 25'h0};
      {lowset_delayed_start, ef_lowset_delayed_start, ext_reclose_req} = 3'h0;
      {thermal_alarm, phase_discont_trip, thermal_trip, manual_clear} = 4'h0;
      tick(5);
      rst = 1'b0;
      t_regs();
      t_inhibit();
      t_trip_block();
      t_init_block();
      t_indication();
      complete_run();
   end
endmodule

bind reclose_block_ctrl reclose_block_ctrl_checker i_reclose_block_ctrl_checker (.mclk, .rst,
   .set_wr, .set_sel, .set_data, .stage_trip, .ext_reclose_req, .shot_number, .manual_clear,
   .trip_out, .shot_start_ok, .auto_reclose_inhibit, .indication_shown, .indication_valid,
   .retain_flags, .battery_supervision_en, .rd_shot_init, .rd_stage_trip, .rd_inhibit,
   .rd_hold_time);
`default_nettype wire

// [verification/reclose_seq_model.sv]
`default_nettype none
// ------------------------------------------------------------------
// Auto-reclose sequencer stand-in, driven by bench task calls
// ------------------------------------------------------------------
module reclose_seq_model (
   input  wire logic       mclk,
   output var  logic [1:0] shot_number,
   output var  logic       cutout_expired,
   output var  logic       reclaim_expired,
   output var  logic       auto_reclose_lockout,
   output var  logic       close_command
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      shot_number = 2'h0;
      {cutout_expired, reclaim_expired, auto_reclose_lockout, close_command} = 4'h0;
   end
   // Enters a shot just after an edge.
   task automatic start_shot(input logic [1:0] n);
      @(posedge mclk);
      #10 shot_number = n;
   endtask
   // Ends the shot: cutout (1), reclaim (2) or lockout (3), pulsed one cycle.
   task automatic end_shot(input logic [1:0] k);
      @(posedge mclk);
      #10 shot_number = 2'h0;
      {cutout_expired, reclaim_expired, auto_reclose_lockout} =
         {k == 2'h1, k == 2'h2, k == 2'h3};
      @(posedge mclk);
      #10 {cutout_expired, reclaim_expired, auto_reclose_lockout} = 3'h0;
   endtask
   // One-cycle breaker close command.
   task automatic close_pulse();
      @(posedge mclk);
      #10 close_command = 1'b1;
      @(posedge mclk);
      #10 close_command = 1'b0;
   endtask
endmodule
`default_nettype wire
